/* File: inc/dbg_phy_pkg.sv */
package dbg_phy_pkg;
   // Register offsets on the internal register port
   localparam logic [3:0] ADDR_STATUS_A = 4'h0;
   localparam logic [3:0] ADDR_ERR_SIG  = 4'h1;
   localparam logic [3:0] ADDR_CTRL_A   = 4'h2;
   localparam logic [3:0] ADDR_CTRL_B   = 4'h3;
   localparam logic [3:0] ADDR_KEY_STAT = 4'h7;
   // Values after reset
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   // Field positions
   localparam int REV_LSB     = 4;
   localparam int INTERBYTE_BIT = 7;
   localparam int PARIGN_BIT  = 5;
   localparam int TMOOFF_BIT  = 4;
   localparam int RSPSUP_BIT  = 3;
   localparam int NACKSUP_BIT = 4;
   localparam int CONTOFF_BIT = 3;
   localparam int IFDIS_BIT   = 2;
   localparam int UROWKEY_BIT = 5;
   localparam int PROGKEY_BIT = 4;
   localparam int ERSKEY_BIT  = 3;
   // Writable bits of the control registers
   localparam logic [7:0] CTRL_A_MASK = 8'hbf;
   localparam logic [7:0] CTRL_B_MASK = 8'h18;
   // Error codes
   localparam logic [2:0] ERR_NONE       = 3'h0;
   localparam logic [2:0] ERR_PARITY     = 3'h1;
   localparam logic [2:0] ERR_FRAME      = 3'h2;
   localparam logic [2:0] ERR_TIMEOUT    = 3'h3;
   localparam logic [2:0] ERR_START      = 3'h4;
   localparam logic [2:0] ERR_CONTENTION = 3'h7;
   // Guard time: code n gives 128 >> n bit periods, last code none
   localparam logic [7:0] GUARD_BASE_BITS = 8'h80;
   localparam logic [2:0] GUARD_OFF       = 3'h7;
   // One idle character is twelve bit periods; the gap is two
   localparam int         IDLE_CHAR_BITS = 12;
   localparam logic [7:0] IB_GAP_BITS    = 8'(2 * IDLE_CHAR_BITS);
   // Access layer response window in interface clock cycles
   localparam int TIMEOUT_DEF = 65536;
   localparam int TIMEOUT_W   = 17;
   // Transmit sequencer
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_BUSY} tx_state_t;
endpackage

/* File: hw/tick_timer.sv */
// Down counter paced by an enable pulse; done pulses after load_val+1 ticks
module tick_timer #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic         tick,
   input  wire logic         load,
   input  wire logic         cancel,
   input  wire logic [W-1:0] load_val,
   output logic              busy_r,
   output logic              done_r
);
   logic [W-1:0] cnt_r;   // Remaining ticks minus one

   // Counter; a fresh load restarts the wait even while busy
   always_ff @(posedge core_clk) begin
      if (rst || cancel) begin
         busy_r <= 1'b0;
         cnt_r  <= '0;
      end else if (load) begin
         busy_r <= 1'b1;
         cnt_r  <= load_val;
      end else if (busy_r && tick) begin
         if (cnt_r == '0) begin
            busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   // Expiry pulse
   always_ff @(posedge core_clk) begin
      if (rst || cancel || load) begin
         done_r <= 1'b0;
      end else begin
         done_r <= busy_r && tick && (cnt_r == '0);
      end
   end
endmodule

/* File: hw/phy_ctrl_status.sv */
module phy_ctrl_status import dbg_phy_pkg::*; #(
   parameter logic [3:0] REVISION       = 4'h1,       // Arbitrary revision value
   parameter int         TIMEOUT_CYCLES = TIMEOUT_DEF
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       reg_wr,          // Register write strobe
   input  wire logic       reg_rd,          // Register read strobe
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata_r,
   input  wire logic       bit_tick,        // One pulse per link bit period
   input  wire logic       parity_bad,      // Receiver sample faults
   input  wire logic       stop_bad,
   input  wire logic       start_bad,
   input  wire logic       acc_start,       // Access layer request issued
   input  wire logic       acc_resp,        // Access layer answered
   input  wire logic       tx_req,          // Byte waiting, held until ack
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_first,        // First byte after receive
   input  wire logic       tx_multi,        // Part of multi-byte load
   input  wire logic       tx_is_sig,       // Byte is a response signature
   input  wire logic       tx_done,         // Serializer finished the byte
   input  wire logic       tx_drive_en,     // Serializer drives the line
   input  wire logic       tx_drive_lvl,    // Level the serializer drives
   input  wire logic       line_in,         // Line pin, asynchronous
   input  wire logic       sys_rst_evt,     // System reset seen
   input  wire logic       xfer_busy,       // Load or store transfer running
   input  wire logic       iface_enable,    // Interface enable event
   input  wire logic       key_urow_set,
   input  wire logic       key_urow_clr,
   input  wire logic       key_prog_set,
   input  wire logic       key_prog_done,
   input  wire logic       key_erase_set,
   input  wire logic       key_erase_done,
   output logic            tx_ack_r,        // Byte consumed or dropped
   output logic            tx_start_r,      // Start serializing tx_byte_r
   output logic      [7:0] tx_byte_r,
   output logic            nack_req_r,      // Send the NACK signature
   output logic            acc_timeout_r,   // Abort pulse to access layer
   output logic            clk_req_r,       // Clock request of the interface
   output logic            phy_rst_r        // Resets the rest of the interface
);
   logic [7:0] ctrl_a_r;                    // Control A settings
   logic [7:0] ctrl_b_r;                    // Control B settings
   logic [2:0] err_code_r;                  // Latched error code
   logic       key_urow_r;                  // User row key active
   logic       key_prog_r;                  // Programming key active
   logic       key_erase_r;                 // Chip erase key active
   logic       line_s1_r;                   // Synchroniser stages
   logic       line_s2_r;
   tx_state_t  tx_state_r;
   logic [2:0] err_nxt;                     // Error reported this cycle
   logic       srst;                        // Hard or interface reset
   logic       gap_busy;
   logic       gap_done;
   logic       gap_load;
   logic [7:0] gap_len;
   logic       tmo_done;
   logic       tmo_evt;
   logic       cont_evt;
   logic       tx_accept;
   logic       tx_drop;
   logic       wr_b;

   // Interface disable acts as a reset of settings and keys
   assign srst = rst || phy_rst_r;
   assign wr_b = reg_wr && (reg_addr == ADDR_CTRL_B);

   // Control A; reserved bit 6 is never stored
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_a_r <= CTRL_A_RST;
      end else if (reg_wr && reg_addr == ADDR_CTRL_A) begin
         ctrl_a_r <= reg_wdata & CTRL_A_MASK;
      end
   end

   // Control B keeps only the two option bits
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_b_r <= CTRL_B_RST;
      end else if (wr_b) begin
         ctrl_b_r <= reg_wdata & CTRL_B_MASK;
      end
   end

   // Writing the disable bit pulses the interface reset once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phy_rst_r <= 1'b0;
      end else begin
         phy_rst_r <= wr_b && reg_wdata[IFDIS_BIT];
      end
   end

   // Clock request: dropped by disable, raised again by enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clk_req_r <= 1'b1;
      end else if (iface_enable) begin
         clk_req_r <= 1'b1;
      end else if (wr_b && reg_wdata[IFDIS_BIT]) begin
         clk_req_r <= 1'b0;
      end
   end

   // Line pin synchroniser
   always_ff @(posedge core_clk) begin
      if (rst) begin
         line_s1_r <= 1'b1;
         line_s2_r <= 1'b1;
      end else begin
         line_s1_r <= line_in;
         line_s2_r <= line_s1_r;
      end
   end

   // Contention: compare once per bit while we drive our own byte
   assign cont_evt = bit_tick && tx_state_r == TX_BUSY && tx_drive_en
                     && !ctrl_b_r[CONTOFF_BIT]
                     && (line_s2_r != tx_drive_lvl);

   // Response window timer, one tick per interface clock
   tick_timer #(.W(TIMEOUT_W)) u_tmo (
      .core_clk (core_clk),
      .rst      (srst),
      .tick     (1'b1),
      .load     (acc_start),
      .cancel   (acc_resp),
      .load_val (TIMEOUT_W'(TIMEOUT_CYCLES - 1)),
      .busy_r   (),
      .done_r   (tmo_done)
   );
   assign tmo_evt = tmo_done && !ctrl_a_r[TMOOFF_BIT];

   always_ff @(posedge core_clk) begin
      if (srst) begin
         acc_timeout_r <= 1'b0;
      end else begin
         acc_timeout_r <= tmo_evt;
      end
   end

   // Error priority: contention over start, stop, parity, timeout
   always_comb begin
      err_nxt = ERR_NONE;
      if (tmo_evt) begin
         err_nxt = ERR_TIMEOUT;
      end
      if (parity_bad && !ctrl_a_r[PARIGN_BIT]) begin
         err_nxt = ERR_PARITY;
      end
      if (stop_bad) begin
         err_nxt = ERR_FRAME;
      end
      if (start_bad) begin
         err_nxt = ERR_START;
      end
      if (cont_evt) begin
         err_nxt = ERR_CONTENTION;
      end
   end

   // Error code: a new error wins over the clearing read
   always_ff @(posedge core_clk) begin
      if (srst) begin
         err_code_r <= ERR_NONE;
      end else if (err_nxt != ERR_NONE) begin
         err_code_r <= err_nxt;
      end else if (reg_rd && reg_addr == ADDR_ERR_SIG) begin
         err_code_r <= ERR_NONE;
      end
   end

   // Key flags; a set in the clearing cycle wins
   always_ff @(posedge core_clk) begin
      if (srst) begin
         key_urow_r  <= 1'b0;
         key_prog_r  <= 1'b0;
         key_erase_r <= 1'b0;
      end else begin
         key_urow_r  <= key_urow_set || (key_urow_r && !key_urow_clr);
         key_prog_r  <= key_prog_set || (key_prog_r && !key_prog_done);
         key_erase_r <= key_erase_set || (key_erase_r && !key_erase_done);
      end
   end

   // Read data, registered; unmapped addresses and spare bits read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_STATUS_A: reg_rdata_r <= {REVISION, 4'h0};
            ADDR_ERR_SIG:  reg_rdata_r <= {5'h00, err_code_r};
            ADDR_CTRL_A:   reg_rdata_r <= ctrl_a_r;
            ADDR_CTRL_B:   reg_rdata_r <= ctrl_b_r;
            ADDR_KEY_STAT: reg_rdata_r <= {2'h0, key_urow_r, key_prog_r,
                                           key_erase_r, 3'h0};
            default:       reg_rdata_r <= 8'h00;
         endcase
      end
   end

   // NACK on system reset during a transfer unless suppressed
   always_ff @(posedge core_clk) begin
      if (srst) begin
         nack_req_r <= 1'b0;
      end else begin
         nack_req_r <= sys_rst_evt && xfer_busy && !ctrl_b_r[NACKSUP_BIT]
                       && !ctrl_a_r[RSPSUP_BIT];
      end
   end

   // Byte acceptance; the ack blocks a second take of a held request
   assign tx_accept = tx_state_r == TX_IDLE && tx_req && !tx_ack_r;
   assign tx_drop   = tx_accept && tx_is_sig && ctrl_a_r[RSPSUP_BIT];

   // Idle gap before a byte: guard on turnaround, else inter-byte gap
   always_comb begin
      gap_len = 8'h00;
      if (tx_first) begin
         if (ctrl_a_r[2:0] != GUARD_OFF) begin
            gap_len = GUARD_BASE_BITS >> ctrl_a_r[2:0];
         end
      end else if (tx_multi && ctrl_a_r[INTERBYTE_BIT]) begin
         gap_len = IB_GAP_BITS;
      end
   end
   // The first byte never takes the inter-byte gap as well
   assign gap_load = tx_accept && !tx_drop && gap_len != 8'h00;

   // Gap timer counts link bit periods, not core cycles
   tick_timer #(.W(8)) u_gap (
      .core_clk (core_clk),
      .rst      (srst),
      .tick     (bit_tick),
      .load     (gap_load),
      .cancel   (1'b0),
      .load_val (gap_len - 8'h01),
      .busy_r   (gap_busy),
      .done_r   (gap_done)
   );

   // Transmit sequencer
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_state_r <= TX_IDLE;
         tx_ack_r   <= 1'b0;
         tx_start_r <= 1'b0;
         tx_byte_r  <= 8'h00;
      end else begin
         tx_ack_r   <= 1'b0;
         tx_start_r <= 1'b0;
         unique case (tx_state_r)
            TX_IDLE: begin
               if (tx_drop) begin
                  tx_ack_r <= 1'b1;
               end else if (gap_load) begin
                  tx_byte_r  <= tx_data;
                  tx_state_r <= TX_WAIT;
               end else if (tx_accept) begin
                  tx_byte_r  <= tx_data;
                  tx_ack_r   <= 1'b1;
                  tx_start_r <= 1'b1;
                  tx_state_r <= TX_BUSY;
               end
            end
            TX_WAIT: begin
               // Wait out the idle bits with the line released
               if (gap_done) begin
                  tx_ack_r   <= 1'b1;
                  tx_start_r <= 1'b1;
                  tx_state_r <= TX_BUSY;
               end
            end
            TX_BUSY: begin
               if (tx_done) begin
                  tx_state_r <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_rev_read;
      reg_rd && reg_addr == ADDR_STATUS_A |=> reg_rdata_r == {REVISION, 4'h0};
   endproperty
   a_rev_read: assert property (p_rev_read) else $error("revision read wrong");

   property p_err_clear;
      reg_rd && reg_addr == ADDR_ERR_SIG && err_nxt == ERR_NONE && !phy_rst_r
         |=> err_code_r == ERR_NONE;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error not cleared");

   property p_contention;
      cont_evt && !phy_rst_r |=> err_code_r == ERR_CONTENTION;
   endproperty
   a_contention: assert property (p_contention) else $error("contention lost");

   property p_timeout;
      tmo_evt && !parity_bad && !stop_bad && !start_bad && !cont_evt && !phy_rst_r
         |=> err_code_r == ERR_TIMEOUT ##0 acc_timeout_r;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout code missing");

   property p_parity_ign;
      ctrl_a_r[PARIGN_BIT] && err_code_r != ERR_PARITY |=> err_code_r != ERR_PARITY;
   endproperty
   a_parity_ign: assert property (p_parity_ign) else $error("parity not ignored");

   property p_sig_drop;
      tx_drop && !phy_rst_r |=> tx_ack_r && !tx_start_r && tx_state_r == TX_IDLE;
   endproperty
   a_sig_drop: assert property (p_sig_drop) else $error("signature sent");

   property p_nack_sup;
      nack_req_r |-> $past(!ctrl_b_r[NACKSUP_BIT] && sys_rst_evt && xfer_busy);
   endproperty
   a_nack_sup: assert property (p_nack_sup) else $error("nack not suppressed");

   property p_disable;
      phy_rst_r |-> ($past(iface_enable) || !clk_req_r)
         ##1 ctrl_a_r == CTRL_A_RST && ctrl_b_r == CTRL_B_RST && err_code_r == ERR_NONE
             && !key_prog_r && !key_urow_r && !key_erase_r;
   endproperty
   a_disable: assert property (p_disable) else $error("disable left state");

   property p_guard_off;
      tx_accept && !tx_drop && tx_first && ctrl_a_r[2:0] == GUARD_OFF && !phy_rst_r
         |=> tx_start_r;
   endproperty
   a_guard_off: assert property (p_guard_off) else $error("guard not skipped");

   property p_prog_clear;
      key_prog_done && !key_prog_set |=> !key_prog_r;
   endproperty
   a_prog_clear: assert property (p_prog_clear) else $error("key not cleared");

   c_gap_wait: cover property (tx_state_r == TX_WAIT ##[1:400] tx_start_r);
   c_timeout:  cover property (tmo_evt);
   c_drop:     cover property (tx_drop);
endmodule

/* File: bench/line_partner.sv */
// Serializer and line model on the far side of the transmit port
module line_partner (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       bit_tick,     // Link bit period pulse
   input  wire logic       tx_start_r,   // Start request from the block
   input  wire logic [7:0] tx_byte_r,    // Byte to put on the line
   input  wire logic       collide,      // Other party fights the line
   output logic            tx_done,      // Frame finished
   output logic            tx_drive_en,  // Model drives the line
   output logic            tx_drive_lvl, // Level the model drives
   output logic            line_in       // Resolved line level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] sh_r;                    // Frame bits, sent LSB first
   logic [3:0]  n_r;                     // Bits still to send
   // Bits advance just after a tick so the synced line settles before the next one
   always_ff @(posedge core_clk) begin
      if (rst) begin
         n_r     <= 4'h0;
         sh_r    <= 11'h7ff;
         tx_done <= 1'b0;
      end else begin
         tx_done <= bit_tick && (n_r == 4'h1);
         if (tx_start_r) begin
            // Leading idle bit keeps the first compare clean
            sh_r <= {1'b1, tx_byte_r, 1'b0, 1'b1};
            n_r  <= 4'hb;
         end else if (bit_tick && (n_r != 4'h0)) begin
            sh_r <= {1'b1, sh_r[10:1]};
            n_r  <= n_r - 4'h1;
         end
      end
   end
   assign tx_drive_en  = (n_r != 4'h0);
   assign tx_drive_lvl = sh_r[0];
   // Pull-up holds the line high when nobody drives it
   assign line_in = tx_drive_en ? (tx_drive_lvl ^ collide) : 1'b1;
endmodule

/* File: bench/phy_ctrl_status_test.sv */
// Self-checking bench for the interface control and status block
module phy_ctrl_status_test import dbg_phy_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         TMO = 20;      // Short response window
   localparam logic [3:0] REV = 4'h1;    // Arbitrary revision value
   logic core_clk, rst, reg_wr, reg_rd, parity_bad, stop_bad, start_bad;
   logic acc_start, acc_resp, tx_req, tx_first, tx_multi, tx_is_sig, collide;
   logic sys_rst_evt, xfer_busy, iface_enable, key_urow_set, key_urow_clr;
   logic key_prog_set, key_prog_done, key_erase_set, key_erase_done;
   logic tx_done, tx_drive_en, tx_drive_lvl, line_in, tx_ack_r, tx_start_r;
   logic nack_req_r, acc_timeout_r, clk_req_r, phy_rst_r, st;
   logic       bit_tick = 1'b0;          // Baud enable, every fourth cycle
   logic [1:0] ph       = 2'h0;          // Baud divider phase
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_r, tx_data, tx_byte_r, d;
   int         err_total, num_checks, tick_cnt, n, t;
   phy_ctrl_status #(.REVISION(REV), .TIMEOUT_CYCLES(TMO)) dut (.*);
   line_partner far (.*);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      ph       <= ph + 2'h1;
      bit_tick <= (ph == 2'h3);
   end
   // Bit periods elapsed, used to measure gaps
   always @(posedge core_clk) tick_cnt <= tick_cnt + int'(bit_tick);
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(negedge core_clk);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = v;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      chk(reg_rdata_r, exp);
   endtask
   task automatic pulse(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask
   // Bounded wait; a wait that must succeed ends the run when it runs out
   task automatic wait_sig(ref logic s, input int lim, input bit must, output int k);
      k = 0;
      while (k < lim && s !== 1'b1) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      if (must && k == lim) begin
         err_total++;
         end_sim();
      end
   endtask
   // One byte through the sequencer; ticks counts bit periods before the answer
   task automatic send(input logic f, m, s, output int ticks, output logic go);
      int t0;
      int k;
      @(negedge core_clk);
      tx_req    = 1'b1;
      tx_first  = f;
      tx_multi  = m;
      tx_is_sig = s;
      tx_data   = 8'($urandom);
      t0        = tick_cnt;
      wait_sig(tx_ack_r, 1500, 1, k);
      go    = tx_start_r;
      ticks = tick_cnt - t0;
      if (go === 1'b1) chk(tx_byte_r, tx_data);
      @(negedge core_clk);
      tx_req = 1'b0;
      if (go === 1'b1) wait_sig(tx_done, 100, 1, k);
   endtask
   function automatic int gap(input logic [2:0] sel);
      return (sel == 3'h7) ? 0 : (128 >> sel);
   endfunction
   initial begin
      {rst, reg_wr, reg_rd, parity_bad, stop_bad, start_bad, acc_start} = '0;
      {acc_resp, tx_req, tx_first, tx_multi, tx_is_sig, collide, sys_rst_evt} = '0;
      {xfer_busy, iface_enable, key_urow_set, key_urow_clr, key_prog_set} = '0;
      {key_prog_done, key_erase_set, key_erase_done, reg_addr, reg_wdata} = '0;
      {tx_data, err_total, num_checks, tick_cnt} = '0;
      rst = 1'b1;
      void'($urandom(32'h44e502d2));
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      chk(clk_req_r, 1'b1);
      rdchk(ADDR_STATUS_A, {REV, 4'h0});
      for (int a = 1; a < 16; a++) rdchk(4'(a), 8'h00);
      repeat (6) begin
         d = 8'($urandom);
         wr(ADDR_CTRL_A, d);
         rdchk(ADDR_CTRL_A, d & CTRL_A_MASK);
         wr(ADDR_CTRL_B, d & 8'hfb);
         rdchk(ADDR_CTRL_B, d & CTRL_B_MASK);
         wr(4'h5, d);
         rdchk(4'h5, 8'h00);
      end
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_CTRL_B, 8'h00);
      pulse(parity_bad);
      rdchk(ADDR_ERR_SIG, 8'h01);
      rdchk(ADDR_ERR_SIG, 8'h00);
      pulse(stop_bad);
      rdchk(ADDR_ERR_SIG, 8'h02);
      pulse(start_bad);
      rdchk(ADDR_ERR_SIG, 8'h04);
      wr(ADDR_CTRL_A, 8'h20);
      pulse(parity_bad);
      rdchk(ADDR_ERR_SIG, 8'h00);
      wr(ADDR_CTRL_A, 8'h00);
      pulse(acc_start);
      wait_sig(acc_timeout_r, 60, 1, n);
      chk(8'(n >= TMO - 1 && n <= TMO + 1), 8'h01);
      rdchk(ADDR_ERR_SIG, 8'h03);
      pulse(acc_start);
      repeat (5) @(negedge core_clk);
      pulse(acc_resp);
      wait_sig(acc_timeout_r, 40, 0, n);
      chk(8'(n), 8'd40);
      wr(ADDR_CTRL_A, 8'h10);
      pulse(acc_start);
      wait_sig(acc_timeout_r, 40, 0, n);
      chk(8'(n), 8'd40);
      // Every guard selection, measured in link bit periods
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_CTRL_A, 8'(s));
         send(1'b1, 1'b0, 1'b0, t, st);
         chk(st, 1'b1);
         chk(8'(t >= gap(3'(s)) && t <= gap(3'(s)) + 1), 8'h01);
      end
      rdchk(ADDR_ERR_SIG, 8'h00);
      wr(ADDR_CTRL_A, 8'h86);
      send(1'b0, 1'b1, 1'b0, t, st);
      chk(8'(t >= 24 && t <= 25), 8'h01);
      send(1'b1, 1'b1, 1'b0, t, st);
      chk(8'(t >= 2 && t <= 3), 8'h01);
      wr(ADDR_CTRL_A, 8'h07);
      send(1'b0, 1'b1, 1'b0, t, st);
      chk(8'(t <= 1), 8'h01);
      wr(ADDR_CTRL_A, 8'h0f);
      send(1'b0, 1'b0, 1'b1, t, st);
      chk(st, 1'b0);
      xfer_busy = 1'b1;
      pulse(sys_rst_evt);
      wait_sig(nack_req_r, 5, 0, n);
      chk(8'(n), 8'd5);
      wr(ADDR_CTRL_A, 8'h07);
      pulse(sys_rst_evt);
      wait_sig(nack_req_r, 5, 1, n);
      chk(8'(n), 8'd0);
      wr(ADDR_CTRL_B, 8'h10);
      pulse(sys_rst_evt);
      wait_sig(nack_req_r, 5, 0, n);
      chk(8'(n), 8'd5);
      xfer_busy = 1'b0;
      wr(ADDR_CTRL_B, 8'h00);
      collide = 1'b1;
      send(1'b1, 1'b0, 1'b0, t, st);
      rdchk(ADDR_ERR_SIG, 8'h07);
      wr(ADDR_CTRL_B, 8'h08);
      send(1'b1, 1'b0, 1'b0, t, st);
      rdchk(ADDR_ERR_SIG, 8'h00);
      collide = 1'b0;
      for (int r = 0; r < 2; r++) begin
         @(negedge core_clk);
         {key_urow_set, key_prog_set, key_erase_set} = 3'h7;
         @(negedge core_clk);
         {key_urow_set, key_prog_set, key_erase_set} = 3'h0;
         rdchk(ADDR_KEY_STAT, 8'h38);
         if (r == 0) begin
            pulse(key_prog_done);
            rdchk(ADDR_KEY_STAT, 8'h28);
            pulse(key_erase_done);
            rdchk(ADDR_KEY_STAT, 8'h20);
            pulse(key_urow_clr);
            rdchk(ADDR_KEY_STAT, 8'h00);
         end
      end
      wr(ADDR_CTRL_A, 8'hbf);
      wr(ADDR_CTRL_B, 8'h1c);
      wait_sig(phy_rst_r, 3, 1, n);
      chk(clk_req_r, 1'b0);
      repeat (2) @(negedge core_clk);
      rdchk(ADDR_CTRL_A, CTRL_A_RST);
      rdchk(ADDR_CTRL_B, CTRL_B_RST);
      rdchk(ADDR_KEY_STAT, 8'h00);
      pulse(iface_enable);
      @(negedge core_clk);
      chk(clk_req_r, 1'b1);
      end_sim();
   end
endmodule
